// File: logic/panel_control.sv
// Purpose: test pushbutton command decode and status indicator drive
// Assumes: apb slave with zero wait states, button, data and power pins synchronised here
// Notes:   hold-time thresholds are module parameters for simulation
`timescale 1ns/100ps

// How it works
// - a release before five seconds of hold starts wire test.
// - a release in five to ten seconds aligns toward the exchange side.
// - a release after ten seconds aligns toward a station termination.
// - align led is steady in command, alignment or transponder mode.
// - the alignment indicator flashes in loopback mode.
// - the failure indicator is steady on a reported internal failure.
// - the failure indicator flashes while wire test is active.
// - all four mode and activity indicators are dark when idle.
// - the transmit indicator flashes while customer data arrives.
// - the receive indicator flashes while data goes toward the customer.
// - the line power indicator follows presence of simplex current.
// - the local power indicator follows presence of local supply.
// - the sealing current supply works only under local power.
// - wire test ends on a second short press or after one hour.
module panel_control
    import panel_pkg::*;
#(
    parameter int unsigned DEBOUNCE = DEBOUNCE_CYCLES,
    parameter int unsigned SHORT_CY = CLOCK_HZ * SHORT_HOLD_S,
    parameter int unsigned LONG_CY  = CLOCK_HZ * LONG_HOLD_S,
    parameter longint unsigned WIRE_CY = 64'(CLOCK_HZ) * WIRE_TEST_S,
    parameter int unsigned FLASH    = FLASH_CYCLES,
    parameter int unsigned ACT_HOLD = ACT_CYCLES
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_button_n,
    input  wire unit_mode_t  i_mode,
    input  wire logic        i_customer_data_in,
    input  wire logic        i_customer_data_out,
    input  wire logic        i_simplex_present,
    input  wire logic        i_local_present,
    input  wire logic        i_sealing_current_select,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output commands_t        o_command,
    output logic             o_wire_test_active,
    output logic             o_sealing_supply_on,
    output leds_t            o_leds,
    output logic             o_irq
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            // idle levels: button released, all else absent
            sync_a <= 5'h10;
            sync_b <= 5'h10;
        end else begin
            sync_a <= {i_button_n, i_customer_data_in, i_customer_data_out,
                       i_simplex_present, i_local_present};
            sync_b <= sync_a;
        end
    end
    wire button_raw = ~sync_b[4];
    wire data_in_s  = sync_b[3];
    wire data_out_s = sync_b[2];
    wire simplex_s  = sync_b[1];
    wire local_s    = sync_b[0];

    // ------------------------------------------------------------
    // debounce and hold timing
    // ------------------------------------------------------------
    button_state_t btn, next_btn;
    logic [31:0] deb_cnt, next_deb_cnt;
    logic [31:0] hold_cnt, next_hold_cnt;
    commands_t   cmd, next_cmd;
    always_comb begin
        next_btn      = btn;
        next_deb_cnt  = 32'h0;
        next_hold_cnt = hold_cnt;
        next_cmd      = '0;
        if ((btn == BTN_DOWN) != button_raw) begin
            next_deb_cnt = deb_cnt + 32'h1;
            if (deb_cnt >= 32'(DEBOUNCE - 1)) begin
                next_deb_cnt = 32'h0;
                if (btn == BTN_UP) begin
                    next_btn      = BTN_DOWN;
                    next_hold_cnt = 32'h0;
                end else begin
                    next_btn = BTN_UP;
                    if (hold_cnt < 32'(SHORT_CY))
                        next_cmd.wire_test = 1'b1;
                    else if (hold_cnt > 32'(SHORT_CY) &&
                             hold_cnt < 32'(LONG_CY))
                        next_cmd.align_exchange = 1'b1;
                    else if (hold_cnt > 32'(LONG_CY))
                        next_cmd.align_station = 1'b1;
                end
            end
        end
        if (btn == BTN_DOWN && hold_cnt != 32'hFFFF_FFFF)
            next_hold_cnt = hold_cnt + 32'h1;
    end
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            btn      <= BTN_UP;
            deb_cnt  <= 32'h0;
            hold_cnt <= 32'h0;
            cmd      <= '0;
        end else begin
            btn      <= next_btn;
            deb_cnt  <= next_deb_cnt;
            hold_cnt <= next_hold_cnt;
            cmd      <= next_cmd;
        end
    end

    // ------------------------------------------------------------
    // wire test mode and timeout
    // ------------------------------------------------------------
    logic        wire_test, next_wire_test;
    logic [63:0] wt_cnt, next_wt_cnt;
    logic        wt_end, next_wt_end;
    always_comb begin
        next_wire_test = wire_test;
        next_wt_cnt    = wt_cnt;
        next_wt_end    = 1'b0;
        if (wire_test) begin
            next_wt_cnt = wt_cnt + 64'h1;
            if (next_cmd.wire_test || wt_cnt >= WIRE_CY - 1) begin
                next_wire_test = 1'b0;
                next_wt_end    = 1'b1;
            end
        end else if (next_cmd.wire_test) begin
            next_wire_test = 1'b1;
            next_wt_cnt    = 64'h0;
        end
    end
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            wire_test <= 1'b0;
            wt_cnt    <= 64'h0;
            wt_end    <= 1'b0;
        end else begin
            wire_test <= next_wire_test;
            wt_cnt    <= next_wt_cnt;
            wt_end    <= next_wt_end;
        end
    end

    // ------------------------------------------------------------
    // flash timebase and activity stretch
    // ------------------------------------------------------------
    logic [31:0] fl_cnt, next_fl_cnt;
    logic        flash, next_flash;
    logic [31:0] tx_cnt, next_tx_cnt;
    logic [31:0] rx_cnt, next_rx_cnt;
    always_comb begin
        next_fl_cnt = fl_cnt + 32'h1;
        next_flash  = flash;
        if (fl_cnt >= 32'(FLASH - 1)) begin
            next_fl_cnt = 32'h0;
            next_flash  = ~flash;
        end
        next_tx_cnt = (tx_cnt != 32'h0) ? tx_cnt - 32'h1 : 32'h0;
        next_rx_cnt = (rx_cnt != 32'h0) ? rx_cnt - 32'h1 : 32'h0;
        if (data_in_s)
            next_tx_cnt = 32'(ACT_HOLD);
        if (data_out_s)
            next_rx_cnt = 32'(ACT_HOLD);
    end
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            fl_cnt <= 32'h0;
            flash  <= 1'b0;
            tx_cnt <= 32'h0;
            rx_cnt <= 32'h0;
        end else begin
            fl_cnt <= next_fl_cnt;
            flash  <= next_flash;
            tx_cnt <= next_tx_cnt;
            rx_cnt <= next_rx_cnt;
        end
    end

    // ------------------------------------------------------------
    // apb registers and interrupt
    // ------------------------------------------------------------
    logic [EV_WIDTH-1:0] status, next_status;
    logic [EV_WIDTH-1:0] mask, next_mask;
    logic [1:0]          control, next_control;
    logic [31:0]         rdata, next_rdata;
    wire access = i_psel && i_penable;
    wire wr     = access && i_pwrite;
    wire rd     = access && !i_pwrite;
    wire [EV_WIDTH-1:0] events = {wt_end, next_cmd.align_station,
                                  next_cmd.align_exchange,
                                  next_cmd.wire_test};
    always_comb begin
        next_status  = status;
        next_mask    = mask;
        next_control = control;
        next_rdata   = rdata;
        if (rd) begin
            unique case (i_paddr)
                ADDR_STATUS:  next_rdata = 32'(status);
                ADDR_MASK:    next_rdata = 32'(mask);
                ADDR_CONTROL: next_rdata = 32'(control);
                ADDR_STATE:   next_rdata = 32'({local_s, simplex_s,
                                                wire_test, i_mode});
                default:      next_rdata = 32'h0;
            endcase
            if (i_paddr == ADDR_STATUS)
                next_status = '0;
        end
        if (wr && i_paddr == ADDR_MASK)
            next_mask = i_pwdata[EV_WIDTH-1:0];
        if (wr && i_paddr == ADDR_CONTROL)
            next_control = i_pwdata[1:0];
        next_status = next_status | events;
    end
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            status  <= '0;
            mask    <= MASK_RESET;
            control <= 2'h0;
            rdata   <= 32'h0;
        end else begin
            status  <= next_status;
            mask    <= next_mask;
            control <= next_control;
            rdata   <= next_rdata;
        end
    end
    assign o_prdata  = next_rdata;
    assign o_pready  = 1'b1;
    assign o_pslverr = 1'b0;
    assign o_irq     = |(status & mask);

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    wire steady_align = (i_mode == MODE_COMMAND) || (i_mode == MODE_ALIGN)
                     || (i_mode == MODE_TRANSPOND);
    always_comb begin
        o_leds.alignment_indicator = steady_align
            || (i_mode == MODE_LOOPBACK && flash);
        o_leds.failure_indicator = control[CTL_FAILURE]
            || (wire_test && flash);
        o_leds.transmit_activity_indicator = (tx_cnt != 32'h0) && flash;
        o_leds.receive_activity_indicator  = (rx_cnt != 32'h0) && flash;
        o_leds.line_power_indicator  = simplex_s;
        o_leds.local_power_indicator = local_s;
    end
    assign o_command           = cmd;
    assign o_wire_test_active  = wire_test;
    assign o_sealing_supply_on = i_sealing_current_select
                              && local_s;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking chk_clk @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    a_short_cmd: assert property (
        cmd.wire_test |-> $past(hold_cnt) < 32'(SHORT_CY))
        else $error("wire test from long hold");
    a_exch_cmd: assert property (
        cmd.align_exchange |-> $past(hold_cnt) > 32'(SHORT_CY)
            && $past(hold_cnt) < 32'(LONG_CY))
        else $error("exchange align out of window");
    a_station_cmd: assert property (
        cmd.align_station |-> $past(hold_cnt) > 32'(LONG_CY))
        else $error("station align too short");
    a_release_only: assert property (
        (cmd != '0) |-> $past(btn) == BTN_DOWN && $past(btn, 2) == BTN_DOWN
            && btn == BTN_UP)
        else $error("command without release");
    a_align_steady: assert property (
        steady_align |-> o_leds.alignment_indicator)
        else $error("align led dark in active mode");
    a_idle_dark: assert property (
        (i_mode == MODE_IDLE && !wire_test && !control[CTL_FAILURE]
         && tx_cnt == 0 && rx_cnt == 0) |-> !o_leds.alignment_indicator
         && !o_leds.failure_indicator && !o_leds.transmit_activity_indicator
         && !o_leds.receive_activity_indicator)
        else $error("led lit while idle");
    // a press seen while the mode was already running must end it
    a_wire_toggle: assert property (
        (cmd.wire_test && $past(wire_test)) |-> !wire_test)
        else $error("wire test not ended by press");
    a_seal_local: assert property (
        (!i_local_present) [*3] |-> !o_sealing_supply_on)
        else $error("sealing supply without local power");
    a_power_leds: assert property (
        $rose(i_simplex_present) ##1 i_simplex_present [*2]
            |-> o_leds.line_power_indicator)
        else $error("line power led lag");
    c_wire_test: cover property (@(posedge i_clock) cmd.wire_test);
    c_exchange: cover property (@(posedge i_clock) cmd.align_exchange);
    c_station: cover property (@(posedge i_clock) cmd.align_station);
    c_wire_end: cover property (@(posedge i_clock) wt_end);
endmodule

// File: logic/panel_pkg.sv
// Purpose: shared constants and types for the front-panel logic
// Assumes: 50 MHz clock
// Notes:   times kept in their own units, debounce, flash and activity cycle counts derived here
package panel_pkg;
    localparam int unsigned CLOCK_HZ        = 50_000_000;
    localparam int unsigned DEBOUNCE_MS     = 20;
    localparam int unsigned DEBOUNCE_CYCLES = CLOCK_HZ / 1000 * DEBOUNCE_MS;
    localparam int unsigned SHORT_HOLD_S    = 5;
    localparam int unsigned LONG_HOLD_S     = 10;
    localparam int unsigned WIRE_TEST_S     = 3600;
    localparam int unsigned FLASH_MS        = 250;
    localparam int unsigned FLASH_CYCLES    = CLOCK_HZ / 1000 * FLASH_MS;
    localparam int unsigned ACT_MS          = 50;
    localparam int unsigned ACT_CYCLES      = CLOCK_HZ / 1000 * ACT_MS;

    // apb register map
    localparam logic [7:0] ADDR_STATUS  = 8'h00;
    localparam logic [7:0] ADDR_MASK    = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_STATE   = 8'h0C;

    // event bits
    localparam int EV_WIRE_TEST  = 0;
    localparam int EV_ALIGN_EXCH = 1;
    localparam int EV_ALIGN_STAT = 2;
    localparam int EV_WIRE_END   = 3;
    localparam int EV_WIDTH      = 4;
    localparam logic [EV_WIDTH-1:0] MASK_RESET = 4'h0;

    // control bits
    localparam int CTL_FAILURE   = 0;
    localparam int CTL_SEAL_REQ  = 1;

    typedef enum logic [2:0] {
        MODE_IDLE      = 3'h0,
        MODE_COMMAND   = 3'h1,
        MODE_ALIGN     = 3'h2,
        MODE_TRANSPOND = 3'h3,
        MODE_LOOPBACK  = 3'h4
    } unit_mode_t;

    typedef enum logic [1:0] {
        BTN_UP   = 2'b00,
        BTN_DOWN = 2'b01
    } button_state_t;

    typedef struct packed {
        logic transmit_activity_indicator;
        logic receive_activity_indicator;
        logic alignment_indicator;
        logic failure_indicator;
        logic line_power_indicator;
        logic local_power_indicator;
    } leds_t;

    typedef struct packed {
        logic wire_test;
        logic align_exchange;
        logic align_station;
    } commands_t;
endpackage

// File: testbench/panel_installer.sv
// Purpose: installer model working the front test button
// Assumes: button reads low while pressed
// Notes:   each press opens with contact bounce
`timescale 1ns/100ps
module panel_installer (
    input  wire logic i_clock,
    output logic      o_button_n
);
    initial o_button_n = 1'b1;

    // bounce, then a clean hold of the given length
    task automatic press(input int hold);
        repeat (3) begin
            @(posedge i_clock);
            o_button_n <= 1'b0;
            @(posedge i_clock);
            o_button_n <= 1'b1;
        end
        @(posedge i_clock);
        o_button_n <= 1'b0;
        repeat (hold) @(posedge i_clock);
        o_button_n <= 1'b1;
    endtask
endmodule

// File: testbench/panel_tb_top.sv
// Purpose: self-checking bench for the front-panel control
// Assumes: shortened counts set by the parameters below
// Notes:   register reads first, then led rows, then button, wire test, interrupt and mid-run reset cases
`timescale 1ns/100ps
module panel_button_and_status_leds_tb_top;
    import panel_pkg::*;
    localparam int WIRE = 1000;
    typedef struct packed {
        unit_mode_t mode;
        logic [5:0] inp;
        logic [6:0] on;
        logic [6:0] off;
        logic [6:0] dc;
    } row_t;
    // inp: fail, din, dout, simplex, local, select
    // led bits: tx rx align fail line local seal
    row_t rows [6] = '{
        '{MODE_IDLE,      6'h05, 7'h04, 7'h7B, 7'h00},
        '{MODE_COMMAND,   6'h07, 7'h17, 7'h68, 7'h00},
        '{MODE_ALIGN,     6'h06, 7'h16, 7'h69, 7'h00},
        '{MODE_TRANSPOND, 6'h00, 7'h10, 7'h6F, 7'h00},
        '{MODE_LOOPBACK,  6'h33, 7'h5B, 7'h34, 7'h40},
        '{MODE_IDLE,      6'h0D, 7'h24, 7'h5B, 7'h20}};
    logic        i_clock, i_rst_n, i_psel, i_penable, i_pwrite;
    logic        i_customer_data_in, i_customer_data_out;
    logic        i_simplex_present, i_local_present;
    logic        i_sealing_current_select, i_button_n;
    logic [7:0]  i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic        o_pready, o_pslverr, o_wire_test_active, o_irq;
    logic        o_sealing_supply_on;
    unit_mode_t  i_mode;
    commands_t   o_command, c;
    leds_t       o_leds;
    logic [6:0]  s1, s0;
    int          n_errors, num_checks;

    panel_control #(.DEBOUNCE(4), .SHORT_CY(100), .LONG_CY(200),
        .WIRE_CY(WIRE), .FLASH(4), .ACT_HOLD(8)) panel_control_inst (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_button_n(i_button_n),
        .i_mode(i_mode), .i_customer_data_in(i_customer_data_in),
        .i_customer_data_out(i_customer_data_out),
        .i_simplex_present(i_simplex_present),
        .i_local_present(i_local_present),
        .i_sealing_current_select(i_sealing_current_select),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr),
        .o_command(o_command), .o_wire_test_active(o_wire_test_active),
        .o_sealing_supply_on(o_sealing_supply_on), .o_leds(o_leds),
        .o_irq(o_irq));
    panel_installer panel_installer_inst (
        .i_clock(i_clock), .o_button_n(i_button_n));

    // -------------------------------------------------
    // tasks
    // -------------------------------------------------
    task automatic chk(input bit ok, input string msg);
        num_checks++;
        if (!ok) begin
            n_errors++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    task automatic apb(input logic we, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge i_clock);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= we;
        i_paddr <= a;
        i_pwdata <= wd;
        @(posedge i_clock);
        i_penable <= 1'b1;
        // request held until pready is seen at a rising edge
        do begin
            @(posedge i_clock);
        end while (o_pready !== 1'b1);
        rd = o_prdata;
        chk(o_pslverr === 1'b0, "slave error response");
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic watch(input int n);
        s1 = '0;
        s0 = '0;
        repeat (n) begin
            @(negedge i_clock);
            s1 = s1 | {o_leds, o_sealing_supply_on};
            s0 = s0 | ~{o_leds, o_sealing_supply_on};
        end
    endtask

    task automatic push(input int hold);
        int n;
        n = 0;
        panel_installer_inst.press(hold);
        while (o_command === 3'b000 && n < 60) begin
            @(negedge i_clock);
            n++;
        end
        c = o_command;
        @(negedge i_clock);
        chk(o_command === 3'b000, "command pulse too long");
    endtask

    task automatic tally_and_finish;
        if (n_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // -------------------------------------------------
    // clock, watchdog, sequence
    // -------------------------------------------------
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    initial begin
        repeat (20000) @(posedge i_clock);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
        {i_customer_data_in, i_customer_data_out} = 2'b00;
        {i_simplex_present, i_local_present} = 2'b00;
        i_sealing_current_select = 1'b0;
        i_mode = MODE_IDLE;
        i_rst_n = 1'b0;
        n_errors = 0;
        num_checks = 0;
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(negedge i_clock);
        chk(o_command === 3'b000 && o_irq === 1'b0, "reset outputs");
        apb(1'b0, ADDR_MASK, 32'h0);
        chk(rd === {28'h0, MASK_RESET}, "mask reset value");
        apb(1'b0, 8'h10, 32'h0);
        chk(rd === 32'h0, "unmapped read");
        foreach (rows[i]) begin
            apb(1'b1, ADDR_CONTROL, {31'h0, rows[i].inp[5]});
            @(posedge i_clock);
            i_mode <= rows[i].mode;
            {i_customer_data_in, i_customer_data_out, i_simplex_present,
             i_local_present, i_sealing_current_select} <= rows[i].inp[4:0];
            repeat (16) @(posedge i_clock);
            watch(24);
            chk(s1 === rows[i].on, "leds lit");
            chk(s1[2:1] === rows[i].on[2:1] &&
                s0[2:1] === rows[i].off[2:1], "power leds");
            chk(((s0 ^ rows[i].off) & ~rows[i].dc) === 7'h00,
                "leds dark or flashing");
            chk(s1[0] === rows[i].on[0] &&
                s0[0] === rows[i].off[0], "sealing supply");
        end
        apb(1'b1, ADDR_CONTROL, 32'h0);
        i_mode <= MODE_IDLE;
        push(50);
        chk(c === 3'b100, "short press");
        chk(o_wire_test_active === 1'b1 && o_irq === 1'b0, "wire start");
        // local absent, simplex present, wire test on, idle mode
        apb(1'b0, ADDR_STATE, 32'h0);
        chk(rd === 32'h0000_0018, "state register");
        watch(24);
        chk(s1[3] === 1'b1 && s0[3] === 1'b1, "fail flash");
        apb(1'b1, ADDR_MASK, 32'hF);
        repeat (3) @(negedge i_clock);
        chk(o_irq === 1'b1, "irq raised");
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[3:0] === 4'h1, "status wire start");
        repeat (3) @(negedge i_clock);
        chk(o_irq === 1'b0, "irq cleared by read");
        push(50);
        chk(o_wire_test_active === 1'b0, "second press");
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[EV_WIRE_END] === 1'b1, "wire end event");
        watch(24);
        chk(s1[3] === 1'b0, "fail dark after wire test");
        push(150);
        chk(c === 3'b010, "middle press");
        push(300);
        chk(c === 3'b001, "long press");
        push(50);
        repeat (WIRE - 100) @(negedge i_clock);
        chk(o_wire_test_active === 1'b1, "wire test early end");
        repeat (200) @(negedge i_clock);
        chk(o_wire_test_active === 1'b0, "wire test timeout");
        // reset in mid-run while wire test and irq are active
        push(50);
        @(posedge i_clock);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(negedge i_clock);
        chk(o_wire_test_active === 1'b0 && o_irq === 1'b0, "mid-run reset");
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd === 32'h0, "status after reset");
        tally_and_finish();
    end
endmodule
